/* File: core/pwrsq_pkg.sv */
package pwrsq_pkg;
  localparam int APB_AW = 8;
  localparam int CLK_NS = 10;
  localparam logic [APB_AW-1:0] A_BUCK = 8'h00;
  localparam logic [APB_AW-1:0] A_PCTL = 8'h04;
  localparam logic [APB_AW-1:0] A_LVL  = 8'h08;
  localparam logic [APB_AW-1:0] A_BGP  = 8'h0C;
  localparam logic [APB_AW-1:0] A_DIS  = 8'h10;
  localparam logic [APB_AW-1:0] A_UCTL = 8'h14;
  localparam logic [APB_AW-1:0] A_STAT = 8'h18;
  localparam logic [APB_AW-1:0] A_PEND = 8'h1C;
  localparam logic [APB_AW-1:0] A_SETP = 8'h20;
  localparam logic [APB_AW-1:0] A_ACK  = 8'h24;
  localparam logic [APB_AW-1:0] A_LUT  = 8'h40;
  localparam logic [APB_AW-1:0] LUT_BYTES = 8'h30;
  localparam int LUT_DEPTH = 12;
  localparam int DOM_N     = 7;
  localparam int DOM_MEM   = 0;
  localparam int DOM_TMR   = 1;
  localparam int DOM_PER   = 2;
  localparam int DOM_COM   = 3;
  localparam int BGP_W     = 16;
  localparam logic [1:0] POR_TICKS = 2'h3;
  localparam logic [1:0] TYP_P0    = 2'h0;
  localparam logic [1:0] TYP_P1    = 2'h1;
  localparam logic [1:0] MST_NONE  = 2'h0;
  localparam logic [1:0] MST_APP   = 2'h1;
  localparam logic [1:0] MST_RADIO = 2'h2;
  localparam int BOOT_NS   = 2000;
  localparam int BG_ON_NS  = 5000;
  localparam int BG_SMP_NS = 1000;
  localparam int BOOT_CYC   = (BOOT_NS + CLK_NS - 1) / CLK_NS;
  localparam int BG_ON_CYC  = (BG_ON_NS + CLK_NS - 1) / CLK_NS;
  localparam int BG_SMP_CYC = (BG_SMP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [BGP_W-1:0] BGP_RST = 16'h0040;

  typedef enum logic [2:0] {
    PS_OFF  = 3'h0,
    PS_BOOT = 3'h1,
    PS_ACT  = 3'h3,
    PS_SLP  = 3'h2,
    PS_RCH  = 3'h6
  } pwrsq_fsm_t;

  // 13-bit wake table entry, msb first
  typedef struct packed {
    logic [1:0] mst;
    logic       com;
    logic       per;
    logic       tmr;
    logic       xtal;
    logic [4:0] id;
    logic [1:0] typ;
  } pwrsq_lut_t;

  typedef struct packed {
    logic bypS;
    logic bypA;
    logic ioRet;
    logic ioReg;
    logic buckSlp;
  } pwrsq_pctl_t;
  localparam pwrsq_pctl_t PCTL_RST = 5'h06;

  typedef struct packed {
    logic       sleepLvl;
    logic [2:0] act;
    logic [2:0] conv;
  } pwrsq_lvl_t;
  localparam pwrsq_lvl_t LVL_RST = 7'h14;

  typedef struct packed {
    logic [2:0] swDom;
    logic       wakeBlock;
  } pwrsq_uctl_t;

  typedef struct packed {
    pwrsq_fsm_t                       fsm;
    logic [2:0]                       batS;
    logic [2:0]                       slowS;
    logic [2:0]                       railS;
    logic                             batF;
    logic                             slowF;
    logic                             railF;
    logic [1:0]                       porCnt;
    logic                             porRel;
    logic                             buckOn;
    pwrsq_pctl_t                      pctl;
    pwrsq_lvl_t                       lvl;
    logic [BGP_W-1:0]                 bgp;
    logic [BGP_W-1:0]                 bgCnt;
    logic [9:0]                       bgTmr;
    logic [9:0]                       bootCnt;
    logic [2:0]                       dis;
    pwrsq_uctl_t                      uctl;
    pwrsq_lut_t [LUT_DEPTH-1:0]       lut;
    logic [LUT_DEPTH-1:0]             pend;
    logic [DOM_N-1:0]                 dom;
    logic [31:0]                      prdata;
    logic                             pslverr;
  } pwrsq_state_t;
endpackage : pwrsq_pkg

/* File: core/pwrsq_top.sv */
// Functional notes
// - buck converter enabled only by software bit
// - buck on turns converter-rail LDO off
// - converter control runs on fast RC clock
// - sleep buck bit replaces retention regulator
// - sleep rail sampled slowly, recharge on undervoltage
// - converter/LDO level 1.1-1.45 V, 50 mV
// - active core level 0.9-1.25 V, 50 mV
// - sleep core level 0.75 or 0.9 V
// - cold boot enables IO, Core_rail_active_regulator regulators
// - sleep entry enables IO and core retention
// - bypass bits tie IO rail to battery
// - periodic bandgap refresh in sleep ticks
// - POR releases after three slow ticks above
// - rail discharge only from software write
// - decide seven domains, crystal, hibernation
// - act after wake, before go-to-sleep
// - triggers from GPIO, timers, software, debug
// - twelve wake table entries, 13 bits
// - entry bits 1:0 select trigger type
// - keep domain on while a master uses
// - software override blocks system wake-up
// - pin number or peripheral id field
// - fired entry sets pending until acknowledged
// - master field zero disables entry
`timescale 1ns/100ps
module pwrsq_top
  import pwrsq_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              batAboveThr,
  input  wire logic              slowRcClk,
  input  wire logic              railUnder,
  input  wire logic [31:0]       gpio0Trig,
  input  wire logic [31:0]       gpio1Trig,
  input  wire logic [15:0]       perTrig,
  input  wire logic [1:0]        masterDeepSleep,
  input  wire logic [DOM_N-1:0]  domainInUse,
  input  wire logic              sleepEnter,
  input  wire logic              wakeFsmDone,
  output logic                   porResetN,
  output logic                   coldBootActive,
  output logic                   buckEnable,
  output logic                   convLdoEnable,
  output logic                   fastRcEnable,
  output logic                   ioRegEnable,
  output logic                   ioRetEnable,
  output logic                   ioBypass,
  output logic                   coreRegEnable,
  output logic                   coreRetEnable,
  output logic                   bandgapEnable,
  output logic                   refSample,
  output logic      [2:0]        convLevel,
  output logic      [2:0]        coreLevel,
  output logic                   coreSleepLevel,
  output logic      [2:0]        dischargeRail,
  output logic      [DOM_N-1:0]  domainOn,
  output logic                   xtalEnable,
  output logic      [1:0]        masterWake,
  output logic                   wakeRequest,
  output logic                   sleepAllowed
);
  logic [1:0]           rstSync;
  logic                 rstSyncN;
  pwrsq_state_t         st;
  pwrsq_state_t         n;
  logic                 slowTick;
  logic                 wr;
  logic                 lutHit;
  logic [APB_AW-1:0]    lutOff;
  logic [3:0]           idx;
  logic [31:0]          rd;
  logic [LUT_DEPTH-1:0] fireV;
  logic [LUT_DEPTH-1:0] ackM;
  logic [LUT_DEPTH-1:0] setM;
  logic                 hit;
  logic                 reqTmr;
  logic                 reqPer;
  logic                 reqCom;
  logic                 reqXtal;
  logic [1:0]           wk;
  logic                 actLike;
  logic                 slp;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstSyncN = rstSync[1];

  assign actLike = (st.fsm == PS_BOOT) || (st.fsm == PS_ACT);
  assign slp     = (st.fsm == PS_SLP) || (st.fsm == PS_RCH);

  always_comb begin
    n = st;
    rd = 32'h0;
    ackM = '0;
    setM = '0;
    hit = 1'b0;
    reqTmr = 1'b0;
    reqPer = 1'b0;
    reqCom = 1'b0;
    reqXtal = 1'b0;
    wk = 2'h0;
    // three-stage pin synchronisers, change taken when stages 2 and 3 agree
    n.batS  = {st.batS[1:0], batAboveThr};
    n.slowS = {st.slowS[1:0], slowRcClk};
    n.railS = {st.railS[1:0], railUnder};
    if (st.batS[1] == st.batS[2]) n.batF = st.batS[1];
    if (st.slowS[1] == st.slowS[2]) n.slowF = st.slowS[1];
    if (st.railS[1] == st.railS[2]) n.railF = st.railS[1];
    slowTick = n.slowF & ~st.slowF;
    // comparator carries the hysteresis, so a low level means below V_TH-V_HYS
    if (!st.batF) begin
      n.porCnt = 2'h0;
      n.porRel = 1'b0;
    end else if (slowTick && !st.porRel) begin
      if (st.porCnt == POR_TICKS - 2'h1) n.porRel = 1'b1;
      else n.porCnt = st.porCnt + 2'h1;
    end
    // wake table evaluation
    for (int i = 0; i < LUT_DEPTH; i++) begin
      case (st.lut[i].typ)
        TYP_P0:  hit = gpio0Trig[st.lut[i].id];
        TYP_P1:  hit = gpio1Trig[st.lut[i].id];
        default: hit = perTrig[st.lut[i].id[3:0]];
      endcase
      fireV[i] = hit && (st.lut[i].mst != MST_NONE);
      if (st.pend[i]) begin
        reqTmr  = reqTmr  | st.lut[i].tmr;
        reqPer  = reqPer  | st.lut[i].per;
        reqCom  = reqCom  | st.lut[i].com;
        reqXtal = reqXtal | st.lut[i].xtal;
        if (st.lut[i].mst == MST_APP) wk[0] = 1'b1;
        if (st.lut[i].mst == MST_RADIO) wk[1] = 1'b1;
      end
    end
    // apb slave, zero wait states
    wr = psel && penable && pwrite;
    lutOff = paddr - A_LUT;
    idx = lutOff[5:2];
    lutHit = (paddr >= A_LUT) && (lutOff < LUT_BYTES);
    case (paddr)
      A_BUCK: rd = 32'(st.buckOn);
      A_PCTL: rd = 32'(st.pctl);
      A_LVL:  rd = 32'(st.lvl);
      A_BGP:  rd = 32'(st.bgp);
      A_DIS:  rd = 32'(st.dis);
      A_UCTL: rd = 32'(st.uctl);
      A_STAT: rd = 32'({st.railF, st.fsm});
      A_PEND: rd = 32'(st.pend);
      A_SETP: rd = 32'h0;
      A_ACK:  rd = 32'h0;
      default: rd = lutHit ? 32'(st.lut[idx]) : 32'h0;
    endcase
    if (psel && !penable) begin
      n.prdata = rd;
      n.pslverr = (paddr[1:0] != 2'h0) ||
                  (!lutHit && (paddr > A_ACK));
    end
    if (wr) begin
      case (paddr)
        A_BUCK: n.buckOn = pwdata[0];
        A_PCTL: n.pctl = pwrsq_pctl_t'(pwdata[4:0]);
        A_LVL:  n.lvl = pwrsq_lvl_t'(pwdata[6:0]);
        A_BGP:  n.bgp = pwdata[BGP_W-1:0];
        A_DIS:  n.dis = pwdata[2:0];
        A_UCTL: n.uctl = pwrsq_uctl_t'(pwdata[3:0]);
        A_SETP: setM = pwdata[LUT_DEPTH-1:0];
        A_ACK:  ackM = pwdata[LUT_DEPTH-1:0];
        default: begin
          if (lutHit && paddr[1:0] == 2'h0) begin
            n.lut[idx] = pwrsq_lut_t'(pwdata[12:0]);
          end
        end
      endcase
    end
    // a fire in the acknowledge cycle survives
    n.pend = (st.pend & ~ackM) | setM | fireV;
    // timer, peripheral and com domains follow pending entries; leaving one on while a master uses it
    if (st.fsm == PS_ACT) begin
      n.dom = {st.uctl.swDom, reqCom, reqPer, reqTmr, 1'b1};
    end else begin
      n.dom = '0;
    end
    n.dom = n.dom | (st.dom & domainInUse);
    // bandgap refresh, only ticks while asleep
    // the interval runs from the end of a refresh: a period shorter than
    // the refresh would otherwise retrigger it before any sample is taken
    if (st.bgTmr != 10'h0) n.bgTmr = st.bgTmr - 10'h1;
    if (!slp) begin
      n.bgCnt = st.bgp;
      n.bgTmr = 10'h0;
    end else if (slowTick && st.bgTmr == 10'h0) begin
      if (st.bgCnt == '0) begin
        n.bgCnt = st.bgp;
        n.bgTmr = 10'(BG_ON_CYC);
      end else begin
        n.bgCnt = st.bgCnt - 16'h1;
      end
    end
    case (st.fsm)
      PS_OFF: begin
        if (st.porRel) begin
          n.fsm = PS_BOOT;
          n.bootCnt = 10'(BOOT_CYC);
        end
      end
      PS_BOOT: begin
        if (st.bootCnt == 10'h0) n.fsm = PS_ACT;
        else n.bootCnt = st.bootCnt - 10'h1;
      end
      PS_ACT: begin
        if (sleepEnter && sleepAllowed) n.fsm = PS_SLP;
      end
      PS_SLP: begin
        if (wakeFsmDone) n.fsm = PS_ACT;
        else if (st.pctl.buckSlp && slowTick && n.railF) n.fsm = PS_RCH;
      end
      PS_RCH: begin
        if (wakeFsmDone) n.fsm = PS_ACT;
        else if (!n.railF) n.fsm = PS_SLP;
      end
      default: n.fsm = PS_OFF;
    endcase
    // all but the synchronisers, por filter, bgCnt, bootCnt, APB read data and pslverr return to defaults
    if (!n.porRel) begin
      n.fsm = PS_OFF;
      n.buckOn = 1'b0;
      n.pctl = PCTL_RST;
      n.lvl = LVL_RST;
      n.bgp = BGP_RST;
      n.dis = 3'h0;
      n.uctl = '0;
      n.lut = '0;
      n.pend = '0;
      n.dom = '0;
      n.bgTmr = 10'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      st <= '0;
    end else begin
      st <= n;
    end
  end

  assign pready = 1'b1;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr;
  assign porResetN = st.porRel;
  assign coldBootActive = (st.fsm == PS_BOOT);
  // in sleep the buck only runs during a recharge burst
  assign buckEnable = ((st.fsm == PS_ACT) && st.buckOn) ||
                      (st.fsm == PS_RCH);
  assign convLdoEnable = (actLike && !buckEnable) ||
                         (slp && !st.pctl.buckSlp);
  assign fastRcEnable = actLike || (st.fsm == PS_RCH);
  assign ioRegEnable = actLike && st.pctl.ioReg && !st.pctl.bypA;
  assign ioRetEnable = slp && st.pctl.ioRet && !st.pctl.bypS;
  assign ioBypass = actLike ? st.pctl.bypA : (slp && st.pctl.bypS);
  assign coreRegEnable = actLike;
  assign coreRetEnable = slp && !st.pctl.buckSlp;
  assign bandgapEnable = actLike || (st.bgTmr != 10'h0);
  assign refSample = slp && (st.bgTmr != 10'h0) &&
                     (st.bgTmr <= 10'(BG_SMP_CYC));
  assign convLevel = st.lvl.conv;
  assign coreLevel = st.lvl.act;
  assign coreSleepLevel = st.lvl.sleepLvl;
  assign dischargeRail = st.dis;
  assign domainOn = st.dom;
  assign xtalEnable = (st.fsm == PS_ACT) && reqXtal;
  assign masterWake = st.uctl.wakeBlock ? 2'h0 : wk;
  assign wakeRequest = slp && (st.pend != '0) && !st.uctl.wakeBlock;
  assign sleepAllowed = (st.pend == '0) && (&masterDeepSleep);

  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rstSyncN);

  buck_sw_only_a: assert property (
    $rose(st.buckOn) |-> $past(wr && paddr == A_BUCK))
    else $error("buck enable set without a software write");
  ldo_handover_a: assert property (
    buckEnable |-> !convLdoEnable)
    else $error("converter LDO on while buck on");
  fast_rc_a: assert property (
    buckEnable |-> fastRcEnable)
    else $error("buck running without fast RC");
  sleep_buck_a: assert property (
    (slp && st.pctl.buckSlp) |-> !coreRetEnable && !convLdoEnable)
    else $error("retention used while sleep buck set");
  recharge_a: assert property (
    (st.fsm == PS_SLP && st.pctl.buckSlp && slowTick && n.railF &&
     n.porRel && !wakeFsmDone) |=> buckEnable && fastRcEnable)
    else $error("no recharge on undervoltage");
  boot_enable_a: assert property (
    coldBootActive |-> coreRegEnable && convLdoEnable && !buckEnable)
    else $error("cold boot regulators wrong");
  sleep_ret_a: assert property (
    (st.fsm == PS_SLP && st.pctl.ioRet && !st.pctl.bypS) |-> ioRetEnable)
    else $error("IO retention off in sleep");
  bg_refresh_a: assert property (
    $rose(refSample) |-> $past(bandgapEnable, 2) && bandgapEnable)
    else $error("sample without settled bandgap");
  por_filter_a: assert property (
    $rose(st.porRel) |-> $past(st.porCnt) == POR_TICKS - 2'h1)
    else $error("POR released early");
  por_drop_a: assert property (
    !st.batF |=> !st.porRel ##1 st.fsm == PS_OFF)
    else $error("POR not reasserted");
  dis_sw_a: assert property (
    (st.dis != $past(st.dis) && st.porRel && $past(st.porRel)) |->
      $past(wr && paddr == A_DIS))
    else $error("discharge changed without write");
  pend_set_a: assert property (
    (fireV != '0 && n.porRel) |=> (st.pend & $past(fireV)) == $past(fireV))
    else $error("fired entry not pending");
  dom_hold_a: assert property (
    n.porRel |=> (st.dom & $past(st.dom & domainInUse)) ==
                 $past(st.dom & domainInUse))
    else $error("domain in use switched off");
  override_a: assert property (
    st.uctl.wakeBlock |-> !wakeRequest && masterWake == 2'h0)
    else $error("wake not overridden");
  ack_clear_a: assert property (
    (ackM != '0 && fireV == '0 && n.porRel) |=>
      (st.pend & $past(ackM)) == '0)
    else $error("acknowledged entry still pending");
  bg_reload_a: assert property (
    (slp && slowTick && st.bgCnt == '0 && st.bgTmr == 10'h0 && n.porRel) |=>
      st.bgCnt == $past(st.bgp) && st.bgTmr == 10'(BG_ON_CYC))
    else $error("refresh interval not reloaded");
  bg_hold_a: assert property (
    (slp && st.bgTmr != 10'h0) |=> st.bgCnt == $past(st.bgCnt))
    else $error("refresh interval counted during refresh");
  wake_act_a: assert property (
    (slp && wakeFsmDone && n.porRel) |=> st.fsm == PS_ACT)
    else $error("no return to active after wake");
  sleep_gate_a: assert property (
    (st.fsm == PS_ACT ##1 st.fsm == PS_SLP) |-> $past(sleepAllowed))
    else $error("sleep entered while not allowed");
  dom_idle_a: assert property (
    (st.fsm != PS_ACT && n.porRel) |=> (st.dom & ~$past(st.dom)) == '0)
    else $error("domain switched on outside active");
  xtal_act_a: assert property (
    xtalEnable |-> st.fsm == PS_ACT && st.pend != '0)
    else $error("crystal requested without pending entry");
  ldo_back_a: assert property (
    (actLike && !buckEnable) |-> convLdoEnable)
    else $error("converter LDO off while buck off");

  boot_c:  cover property ($rose(st.porRel) ##[1:300] st.fsm == PS_ACT);
  sleep_c: cover property (st.fsm == PS_ACT ##1 st.fsm == PS_SLP);
  rch_c:   cover property (st.fsm == PS_RCH ##[1:50] st.fsm == PS_SLP);
  bg_c:    cover property ($rose(refSample));
  wake_c:  cover property (wakeRequest ##[1:20] wakeFsmDone);
endmodule : pwrsq_top

/* File: test/pwrsq_analog_model.sv */
`timescale 1ns/100ps
module pwrsq_analog_model #(
  parameter int DIV = 20
) (
  input  wire logic sys_clk,
  input  wire logic batGood,
  input  wire logic droop,
  input  wire logic buckEnable,
  input  wire logic fastRcEnable,
  output logic      slowRcClk,
  output logic      batAboveThr,
  output logic      railUnder
);
  int div;
  int chg;
  initial begin
    div = 0;
    chg = 0;
    slowRcClk = 1'b0;
    railUnder = 1'b0;
  end
  // the sleep oscillator runs free, also between sleep periods
  always @(posedge sys_clk) begin
    div <= (div == DIV - 1) ? 0 : div + 1;
    slowRcClk <= (div < DIV / 2);
  end
  assign batAboveThr = batGood;
  // rail sags only on command and recovers only while the buck charges it
  always @(posedge sys_clk) begin
    if (droop) begin
      railUnder <= 1'b1;
      chg <= 0;
    end else if (railUnder && buckEnable && fastRcEnable) begin
      chg <= chg + 1;
      if (chg == 8) begin
        railUnder <= 1'b0;
      end
    end
  end
endmodule : pwrsq_analog_model

/* File: test/pwrsq_tb_top.sv */
`timescale 1ns/100ps
module pwrsq_tb_top;
  import pwrsq_pkg::*;
  typedef struct packed {
    logic [APB_AW-1:0] a;
    logic              w;
    logic [31:0]       d;
    logic [31:0]       x;
    logic              e;
  } pwrsq_row_t;
  localparam int DIV = 20;
  logic              sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic              batAboveThr, slowRcClk, railUnder, sleepEnter;
  logic              wakeFsmDone, porResetN, coldBootActive, buckEnable;
  logic              convLdoEnable, fastRcEnable, ioRegEnable, ioRetEnable;
  logic              ioBypass, coreRegEnable, coreRetEnable, bandgapEnable;
  logic              refSample, coreSleepLevel, xtalEnable, wakeRequest;
  logic              sleepAllowed, batGood, droop, rerr;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, gpio0Trig, gpio1Trig, rdat;
  logic [15:0]       perTrig;
  logic [1:0]        masterDeepSleep, masterWake;
  logic [DOM_N-1:0]  domainInUse, domainOn;
  logic [2:0]        convLevel, coreLevel, dischargeRail;
  logic [5:0]        watch;
  int                n_errors, n_compared, cyc, n;
  logic [31:0]       lutv [4] = '{32'h080C, 32'h001D, 32'h1016, 32'h099F};
  pwrsq_row_t        rows [8] = '{
    '{A_PCTL, 1'b0, 32'h0, 32'h06, 1'b0},
    '{A_LVL, 1'b0, 32'h0, 32'h14, 1'b0},
    '{A_BGP, 1'b0, 32'h0, 32'h40, 1'b0},
    '{A_DIS, 1'b0, 32'h0, 32'h00, 1'b0},
    '{A_LVL, 1'b1, 32'h4B, 32'h4B, 1'b0},
    '{8'h6C, 1'b1, 32'hFFFFFFFF, 32'h1FFF, 1'b0},
    '{8'h28, 1'b1, 32'h1, 32'h0, 1'b1},
    '{8'h02, 1'b1, 32'h1, 32'h0, 1'b1}};

  pwrsq_top i_dut (
    .sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .batAboveThr, .slowRcClk, .railUnder, .gpio0Trig,
    .gpio1Trig, .perTrig, .masterDeepSleep, .domainInUse, .sleepEnter,
    .wakeFsmDone, .porResetN, .coldBootActive, .buckEnable, .convLdoEnable,
    .fastRcEnable, .ioRegEnable, .ioRetEnable, .ioBypass, .coreRegEnable,
    .coreRetEnable, .bandgapEnable, .refSample, .convLevel, .coreLevel,
    .coreSleepLevel, .dischargeRail, .domainOn, .xtalEnable, .masterWake,
    .wakeRequest, .sleepAllowed);
  pwrsq_analog_model #(.DIV(DIV)) i_model (
    .sys_clk, .batGood, .droop, .buckEnable, .fastRcEnable, .slowRcClk,
    .batAboveThr, .railUnder);

  assign watch = {refSample, bandgapEnable, fastRcEnable, ioRetEnable,
                  coldBootActive, porResetN};

  task automatic complete_run();
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  // one APB transfer, entered and left at a rising edge
  task automatic apb(input logic w, input logic [APB_AW-1:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic settle();
    @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic waitb(input int i, input logic v, input int lim);
    n = 0;
    while (watch[i] !== v && n < lim) begin
      settle();
      n++;
    end
    chk($sformatf("watch%0d", i), {31'h0, v}, {31'h0, watch[i]});
  endtask : waitb

  task automatic wake();
    @(posedge sys_clk);
    sleepEnter <= 1'b0;
    wakeFsmDone <= 1'b1;
    @(posedge sys_clk);
    wakeFsmDone <= 1'b0;
    waitb(2, 1'b0, 20);
  endtask : wake

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ceiling is several times the expected run length
  initial cyc = 0;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    {rstn, psel, penable, pwrite, batGood, droop} = '0;
    {sleepEnter, wakeFsmDone, paddr, pwdata} = '0;
    {gpio0Trig, gpio1Trig, perTrig, masterDeepSleep, domainInUse} = '0;
    n_errors = 0;
    n_compared = 0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    batGood <= 1'b1;
    waitb(0, 1'b1, 300);
    chk("porDelay", 32'h1, {31'h0, n > 2 * DIV});
    waitb(1, 1'b1, 20);
    waitb(1, 1'b0, 300);
    chk("boot", 4'hE, {convLdoEnable, ioRegEnable, coreRegEnable, buckEnable});
    chk("fastAct", 1, fastRcEnable);
    foreach (rows[i]) begin
      if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk($sformatf("row%0d", i), rows[i].x, rdat);
      chk($sformatf("err%0d", i), {31'h0, rows[i].e}, {31'h0, rerr});
    end
    chk("levels", 7'h4B, {coreSleepLevel, coreLevel, convLevel});
    apb(1'b1, A_BUCK, 32'h1);
    settle();
    chk("buckOn", 2'b10, {buckEnable, convLdoEnable});
    apb(1'b1, A_BUCK, 32'h0);
    settle();
    chk("buckOff", 2'b01, {buckEnable, convLdoEnable});
    apb(1'b1, A_DIS, 32'h5);
    settle();
    chk("discharge", 3'h5, dischargeRail);
    apb(1'b1, A_PCTL, 32'h0E);
    settle();
    chk("bypass", 1, ioBypass);
    apb(1'b1, A_PCTL, 32'h06);
    settle();
    chk("bypassOff", 0, ioBypass);
    for (int i = 0; i < LUT_DEPTH; i++) apb(1'b1, A_LUT + 8'(4 * i), 32'h0);
    foreach (lutv[i]) apb(1'b1, A_LUT + 8'(4 * i), lutv[i]);
    gpio0Trig <= 32'h8;
    gpio1Trig <= 32'h80;
    perTrig <= 16'hA0;
    @(posedge sys_clk);
    {gpio0Trig, gpio1Trig, perTrig} <= '0;
    repeat (3) @(posedge sys_clk);
    apb(1'b0, A_PEND, 32'h0);
    chk("pending", 32'h00D, rdat);
    apb(1'b1, A_ACK, 32'h005);
    apb(1'b0, A_PEND, 32'h0);
    chk("ack", 32'h008, rdat);
    apb(1'b1, A_SETP, 32'h800);
    apb(1'b0, A_PEND, 32'h0);
    chk("setPend", 32'h808, rdat);
    settle();
    chk("pdAct", 32'h1074, {pready, domainOn, xtalEnable, masterWake,
                            sleepAllowed, wakeRequest});
    apb(1'b1, A_ACK, 32'hFFF);
    apb(1'b1, A_BGP, 32'h2);
    masterDeepSleep <= 2'b11;
    domainInUse <= 7'h05;
    sleepEnter <= 1'b1;
    waitb(2, 1'b1, 50);
    chk("coreRet", 1, coreRetEnable);
    chk("domKeep", 7'h01, domainOn);
    apb(1'b0, A_STAT, 32'h0);
    chk("fsmSleep", {29'h0, PS_SLP}, {29'h0, rdat[2:0]});
    waitb(4, 1'b1, 200);
    waitb(5, 1'b1, 600);
    waitb(4, 1'b0, 200);
    waitb(4, 1'b1, 200);
    apb(1'b1, A_SETP, 32'h1);
    settle();
    chk("wakeReq", 3'h5, {wakeRequest, masterWake});
    apb(1'b1, A_UCTL, 32'h1);
    settle();
    chk("wakeBlock", 3'h0, {wakeRequest, masterWake});
    apb(1'b1, A_UCTL, 32'h0);
    apb(1'b1, A_ACK, 32'h1);
    wake();
    chk("coreRetWake", 0, coreRetEnable);
    apb(1'b1, A_PCTL, 32'h07);
    sleepEnter <= 1'b1;
    waitb(2, 1'b1, 50);
    chk("buckSleep", 2'b00, {coreRetEnable, fastRcEnable});
    @(posedge sys_clk);
    droop <= 1'b1;
    @(posedge sys_clk);
    droop <= 1'b0;
    waitb(3, 1'b1, 80);
    waitb(3, 1'b0, 100);
    wake();
    @(posedge sys_clk);
    batGood <= 1'b0;
    waitb(0, 1'b0, 20);
    settle();
    chk("porOff", 3'h0, {convLdoEnable, coreRegEnable, buckEnable});
    chk("domOff", 7'h00, domainOn);
    apb(1'b0, A_PCTL, 32'h0);
    chk("pctlRst", 32'h06, rdat);
    complete_run();
  end
endmodule : pwrsq_tb_top
